/* clk_sel_pkg.sv */
package clk_sel_pkg;
  // register byte offsets
  localparam logic [4:0] A_SEL    = 5'h00;
  localparam logic [4:0] A_CONF   = 5'h04;
  localparam logic [4:0] A_CAM    = 5'h08;
  localparam logic [4:0] A_GATE   = 5'h0C;
  localparam logic [4:0] A_DELAY  = 5'h10;
  localparam logic [4:0] A_STAT   = 5'h14;
  localparam logic [4:0] A_BALL   = 5'h18;
  localparam logic [4:0] A_COMPAT = 5'h1C;
  // field layout
  localparam int          SEL_W     = 20;
  localparam int          DISP_SEL  = 16;
  localparam int          DIV_LSB   = 17;
  localparam int          UART_LSB  = 0;
  localparam int          CARD_BIT  = 2;
  localparam int          CAMS_BIT  = 3;
  localparam int          HIGHZ_BIT = 4;
  localparam int          RTCPD_BIT = 5;
  localparam int          OSCPD_BIT = 6;
  localparam int          GPIO_IDLE = 2;
  localparam logic [2:0]  BALL_SYSCLK = 3'h6;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  // gate groups and mux slots
  localparam int G_TMR  = 0;
  localparam int G_UART = 1;
  localparam int G_CARD = 2;
  localparam int G_CAM  = 3;
  localparam int G_DISP = 4;
  localparam int G_USB  = 5;
  localparam int NGATE  = 6;
  localparam int NTMR   = 8;
  localparam int M_UART = 8;
  localparam int M_CARD = 9;
  localparam int M_CAM  = 10;
  localparam int M_GPIO = 11;
  localparam int M_DISP = 12;
  localparam int M_USB  = 13;
  localparam int NMUX   = 14;
  // timing
  localparam int DELAY_MS  = 32;
  localparam int CLK_MHZ   = 100;
  localparam int DELAY_CYC = DELAY_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {ST_STRAP = 2'h0, ST_WAIT = 2'h1, ST_RUN = 2'h3} st_t;

  typedef struct packed {
    st_t                   st;
    logic                  alt;
    logic [31:0]           dly;
    logic [SEL_W-1:0]      sel;
    logic [6:0]            conf;
    logic [2:0]            cam;
    logic [NGATE-1:0]      gate;
    logic [2:0]            ball;
    logic [31:0]           compat;
    logic [NMUX-1:0][1:0]  msel;
    logic [NMUX-1:0]       mclk;
    logic [2:0]            dcnt;
    logic                  dp_q;
    logic                  ic_q;
    logic                  usb_i;
    logic                  sys_o;
    logic                  aw_got;
    logic                  w_got;
    logic [4:0]            awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } state_t;
endpackage

/* clk_source_select.sv */
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module clk_source_select #(
  parameter int DELAY_CYCLES = clk_sel_pkg::DELAY_CYC
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  input  wire logic                          awvalid,
  output      logic                          awready,
  input  wire logic [31:0]                   awaddr,
  input  wire logic                          wvalid,
  output      logic                          wready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  output      logic                          bvalid,
  input  wire logic                          bready,
  output      logic [1:0]                    bresp,
  input  wire logic                          arvalid,
  output      logic                          arready,
  input  wire logic [31:0]                   araddr,
  output      logic                          rvalid,
  input  wire logic                          rready,
  output      logic [31:0]                   rdata,
  output      logic [1:0]                    rresp,
  input  wire logic                          rst_mode_strap,
  input  wire logic                          ext_sysclk_input,
  input  wire logic                          main_osc_input_i,
  output      logic                          main_osc_input_o,
  output      logic                          main_osc_input_oe_b,
  output      logic                          main_osc_lowpower,
  input  wire logic                          rtc_osc_input,
  input  wire logic                          ext_32k_input,
  output      logic                          rtc_osc_powerdown,
  input  wire logic                          timer_external_clock,
  input  wire logic                          fixed_mpu_periph_clock,
  input  wire logic                          clk_48m,
  input  wire logic                          main_dpll_output,
  input  wire logic                          interconnect_clock,
  input  wire logic [clk_sel_pkg::NGATE-1:0] hw_clk_req,
  output      logic                          sysclk_out,
  output      logic [clk_sel_pkg::NTMR-1:0]  timer_fclk,
  output      logic                          uart_two_fclk,
  output      logic                          card_two_fclk,
  output      logic                          camera_fclk,
  output      logic                          gpio_fclk,
  output      logic                          display_fclk,
  output      logic                          usb_iclk,
  output      logic                          usb_fclk
);
  import clk_sel_pkg::*;

  localparam logic [31:0] DLY_LOAD = 32'(DELAY_CYCLES);

  state_t                s;
  state_t                next_s;
  logic [NMUX-1:0][3:0]  src;
  logic [NMUX-1:0][1:0]  req;
  logic [NGATE-1:0]      en;
  logic                  sys_src;
  logic                  clk32;
  logic                  disp_src;
  logic [31:0]           rword;
  logic [31:0]           wword;

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // two-bit field onto mux slot: 0 is off, three live sources above it
  function automatic logic [1:0] slot(input logic on, input logic [1:0] f);
    logic [1:0] r;
    r = 2'h0;
    if (on) begin
      r = (f == 2'h3) ? 2'h3 : f + 2'h1;
    end
    return r;
  endfunction

  // clock sources: strap decides where the system clock may come from
  always_comb begin
    sys_src = s.alt ? ((s.ball == BALL_SYSCLK) & ext_sysclk_input)
                    : main_osc_input_i;
    clk32 = s.conf[RTCPD_BIT] ? ext_32k_input : rtc_osc_input;
    disp_src = s.sel[DISP_SEL] ? (main_dpll_output & (s.dcnt == 3'h0))
                               : main_dpll_output;
    en = s.gate | hw_clk_req;
  end

  // every mux owns slot 0 tied low, so gating rides the same safe switch
  generate
    for (genvar i = 0; i < NTMR; i++) begin : g_tmr
      assign src[i] = {fixed_mpu_periph_clock, timer_external_clock, clk32, 1'b0};
      assign req[i] = slot(en[G_TMR], s.sel[2*i +: 2]);
    end
  endgenerate

  assign src[M_UART] = {clk_48m, s.sys_o, clk32, 1'b0};
  assign req[M_UART] = slot(en[G_UART], s.conf[UART_LSB +: 2]);
  assign src[M_CARD] = {1'b0, clk_48m, fixed_mpu_periph_clock, 1'b0};
  assign req[M_CARD] = slot(en[G_CARD], {1'b0, s.conf[CARD_BIT]});
  assign src[M_CAM]  = {1'b0, clk_48m, fixed_mpu_periph_clock, 1'b0};
  assign req[M_CAM]  = slot(en[G_CAM], {1'b0, s.conf[CAMS_BIT]});
  assign src[M_GPIO] = {2'h0, s.sys_o, 1'b0};
  assign req[M_GPIO] = slot(~s.cam[GPIO_IDLE], 2'h0);
  assign src[M_DISP] = {2'h0, disp_src, 1'b0};
  assign req[M_DISP] = slot(en[G_DISP], 2'h0);
  assign src[M_USB]  = {2'h0, clk_48m, 1'b0};
  assign req[M_USB]  = slot(en[G_USB], 2'h0);

  // read data for the address on the read channel
  always_comb begin
    case (araddr[4:0])
      A_SEL:    rword = 32'(s.sel);
      A_CONF:   rword = 32'(s.conf);
      A_CAM:    rword = 32'(s.cam);
      A_GATE:   rword = 32'(s.gate);
      A_DELAY:  rword = s.dly;
      A_STAT:   rword = {28'h0, s.sys_o, s.alt, s.st};
      A_BALL:   rword = 32'(s.ball);
      A_COMPAT: rword = s.compat;
      default:  rword = 32'h0000_0000;
    endcase
  end

  // next state of the whole block
  always_comb begin
    next_s = s;
    wword = 32'h0000_0000;
    // strap is caught on the first edge after reset release, never under reset
    case (s.st)
      ST_STRAP: begin
        next_s.alt = rst_mode_strap;
        next_s.dly = rst_mode_strap ? 32'h0 : DLY_LOAD;
        next_s.st = rst_mode_strap ? ST_RUN : ST_WAIT;
      end
      ST_WAIT: begin
        if (s.dly == 32'h0) begin
          next_s.st = ST_RUN;
        end else begin
          next_s.dly = s.dly - 32'h1;
        end
      end
      ST_RUN:  next_s.st = ST_RUN;
      default: next_s.st = ST_STRAP;
    endcase
    next_s.sys_o = (s.st == ST_RUN) & sys_src;
    // divider counts on falling edges so a high phase is never cut short
    next_s.dp_q = main_dpll_output;
    if (s.dp_q & ~main_dpll_output) begin
      next_s.dcnt = (s.dcnt >= s.sel[DIV_LSB +: 3]) ? 3'h0 : s.dcnt + 3'h1;
    end
    next_s.ic_q = interconnect_clock;
    if (interconnect_clock & ~s.ic_q) begin
      next_s.usb_i = ~s.usb_i;
    end
    // a mux moves only while its output and the new source are both low
    for (int i = 0; i < NMUX; i++) begin
      if ((s.msel[i] != req[i]) & ~s.mclk[i] & ~src[i][req[i]]) begin
        next_s.msel[i] = req[i];
      end
      next_s.mclk[i] = src[i][next_s.msel[i]];
    end
    // write channel: address and data taken in either order
    if (awvalid & awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr[4:0];
    end
    if (wvalid & wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (s.aw_got & s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OK;
      case (s.awaddr)
        A_SEL: begin
          wword = merge(32'(s.sel), s.wdata, s.wstrb);
          next_s.sel = wword[SEL_W-1:0];
        end
        A_CONF: begin
          wword = merge(32'(s.conf), s.wdata, s.wstrb);
          next_s.conf = wword[6:0];
        end
        A_CAM: begin
          wword = merge(32'(s.cam), s.wdata, s.wstrb);
          next_s.cam = wword[2:0];
        end
        A_GATE: begin
          wword = merge(32'(s.gate), s.wdata, s.wstrb);
          next_s.gate = wword[NGATE-1:0];
        end
        A_DELAY: begin
          wword = merge(s.dly, s.wdata, s.wstrb);
          next_s.dly = wword; // software may cut the wait to zero
        end
        A_BALL: begin
          wword = merge(32'(s.ball), s.wdata, s.wstrb);
          next_s.ball = wword[2:0];
        end
        A_COMPAT: next_s.compat = merge(s.compat, s.wdata, s.wstrb);
        A_STAT:   next_s.bresp = RESP_ERR; // status is read-only
        default:  next_s.bresp = RESP_ERR;
      endcase
    end
    if (s.bvalid & bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid & rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid & arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rword;
      next_s.rresp = (araddr[4:0] > A_COMPAT) ? RESP_ERR : RESP_OK;
    end
  end

  // one register bank; everything returns to defaults on reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // handshakes are combinational, data comes from flops
  assign awready = ~s.aw_got & ~s.bvalid;
  assign wready = ~s.w_got & ~s.bvalid;
  assign arready = ~s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  // pin driven low as an output while high-impedance mode is on
  assign main_osc_input_o = 1'b0;
  assign main_osc_input_oe_b = ~s.conf[HIGHZ_BIT];
  assign main_osc_lowpower = s.alt | s.conf[OSCPD_BIT];
  assign rtc_osc_powerdown = s.conf[RTCPD_BIT];
  assign sysclk_out = s.sys_o;
  assign timer_fclk = s.mclk[NTMR-1:0];
  assign uart_two_fclk = s.mclk[M_UART];
  assign card_two_fclk = s.mclk[M_CARD];
  assign camera_fclk = s.mclk[M_CAM];
  assign gpio_fclk = s.mclk[M_GPIO];
  assign display_fclk = s.mclk[M_DISP];
  assign usb_iclk = s.usb_i;
  assign usb_fclk = s.mclk[M_USB];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // the edge that releases reset still clears the flops, so it may start no check
  AST_ALT_NO_DELAY: assert property (rst_b && (s.st == ST_STRAP) && rst_mode_strap
    |=> (s.st == ST_RUN) ##1 (s.st == ST_RUN)) else $error("alternate mode waited");
  AST_NO_EARLY_SYSCLK: assert property ((s.st != ST_RUN) |-> !sysclk_out)
    else $error("system clock before delay expired");
  AST_ALT_SRC: assert property ((s.st == ST_RUN) && s.alt && (s.ball != BALL_SYSCLK)
    |=> !sysclk_out) else $error("alternate mode clock from wrong source");
  AST_OSC_LOWPWR: assert property (s.alt |-> main_osc_lowpower)
    else $error("oscillator not in low power");
  AST_HIGHZ_DRIVE: assert property (s.conf[HIGHZ_BIT] |-> !main_osc_input_oe_b
    && !main_osc_input_o) else $error("oscillator pin not driven low");
  AST_GPIO_IDLE: assert property (s.cam[GPIO_IDLE] && !gpio_fclk
    |=> (s.msel[M_GPIO] == 2'h0) && !gpio_fclk) else $error("gpio clock runs while idle");
  AST_MUX_CLEAN: assert property ((s.msel[0] != $past(s.msel[0]))
    |-> !$past(s.mclk[0]) && !timer_fclk[0]) else $error("timer mux switched on high");
  AST_USB_HALF: assert property (rst_b && interconnect_clock && !s.ic_q
    |=> usb_iclk != $past(usb_iclk)) else $error("usb interface clock missed edge");
  AST_SEL_WRITE: assert property (s.aw_got && s.w_got && (s.awaddr == A_SEL)
    && (s.wstrb == 4'hF) |=> (s.sel == $past(s.wdata[SEL_W-1:0])) && bvalid)
    else $error("select write not applied");
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import clk_sel_pkg::*;
  localparam int DLY = 20;
  logic             core_clk, rst_b, rst_mode_strap;
  logic             awvalid, wvalid, bready, arvalid, rready;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [31:0]      awaddr, wdata, araddr, rdata;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp;
  logic [4:0]       cnt;
  logic [NGATE-1:0] hw_clk_req;
  logic             oe_b, lowpwr, rtc_pd, sys_o, uart_f, card_f, cam_f, gpio_f;
  logic             disp_f, usb_i, usb_f, probe, model, q1, q2, osc_o;
  logic [NTMR-1:0]  timer_fclk;
  logic [8:0]       srcv;
  logic [15:0]      mon;
  int               watch, src, n, num_errors, checks;

  clk_source_select #(.DELAY_CYCLES(DLY)) u_clk_source_select (
    .core_clk(core_clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .rst_mode_strap(rst_mode_strap),
    .ext_sysclk_input(srcv[6]), .main_osc_input_i(srcv[4]), .main_osc_input_o(osc_o),
    .main_osc_input_oe_b(oe_b), .main_osc_lowpower(lowpwr), .rtc_osc_input(srcv[0]),
    .ext_32k_input(srcv[7] & rtc_pd),
    .rtc_osc_powerdown(rtc_pd), .timer_external_clock(srcv[1]),
    .fixed_mpu_periph_clock(srcv[2]), .clk_48m(srcv[3]), .main_dpll_output(srcv[5]),
    .interconnect_clock(cnt[1]), .hw_clk_req(hw_clk_req), .sysclk_out(sys_o),
    .timer_fclk(timer_fclk), .uart_two_fclk(uart_f), .card_two_fclk(card_f),
    .camera_fclk(cam_f), .gpio_fclk(gpio_f), .display_fclk(disp_f),
    .usb_iclk(usb_i), .usb_fclk(usb_f));

  // each source has its own period or phase so a wrong mux pick shows up
  assign srcv = {1'b0, ~cnt[3], ~cnt[1], cnt[1] ^ cnt[2], ~cnt[2], cnt[0], cnt[1], cnt[2], cnt[3]};
  assign mon = {sys_o, usb_i, usb_f, disp_f, gpio_f, cam_f, card_f, uart_f, timer_fclk};
  assign probe = mon[watch];
  assign model = srcv[src];

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // free source counter plus the expected clock delayed by one and two samples
  always @(posedge core_clk) begin
    cnt <= cnt + 5'h1;
    q1 <= model;
    q2 <= q1;
  end

  task chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task do_reset(input logic strap);
    @(posedge core_clk);
    rst_mode_strap <= strap;
    rst_b <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // write address and data offered together, each released when taken
  task wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no fixed latency assumed: only the watchdog ends a wait that never answers
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({31'h0, bvalid}, 32'h1, "write answer");
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask

  task rd(input logic [31:0] a, exp, msk, input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk({31'h0, rvalid}, 32'h1, "read answer");
    chk(rdata & msk, exp, "rdata");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
  endtask

  // a mux may wait for both levels low, so settle before comparing
  task follow(input int w, s);
    int b1, b2;
    watch = w;
    src = s;
    b1 = 0;
    b2 = 0;
    repeat (40) @(posedge core_clk);
    repeat (32) begin
      @(posedge core_clk);
      #1;
      if (probe !== q1) b1++;
      if (probe !== q2) b2++;
    end
    chk(32'((b1 == 0) || (b2 == 0)), 32'h1, "clock source");
    // back onto the edge so the next stimulus lands on it
    @(posedge core_clk);
  endtask

  // window is a whole number of periods, so the count is exact
  task edges(input int w, len, e);
    int k;
    logic p;
    watch = w;
    k = 0;
    repeat (8) @(posedge core_clk);
    #1;
    p = probe;
    repeat (len) begin
      @(posedge core_clk);
      #1;
      if (probe !== p) k++;
      p = probe;
    end
    chk(32'(k), 32'(e), "edge count");
    @(posedge core_clk);
  endtask

  task conclude;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // default mode: delay wait, reset values, system clock after the wait
  task test_reset_wait;
    do_reset(1'b0);
    rd(32'(A_STAT), 32'h1, 32'hF, RESP_OK);
    rd(32'(A_SEL), 32'h0, 32'hFFFFFFFF, RESP_OK);
    rd(32'(A_CONF), 32'h0, 32'hFFFFFFFF, RESP_OK);
    rd(32'(A_GATE), 32'h0, 32'hFFFFFFFF, RESP_OK);
    chk({31'h0, lowpwr}, 32'h0, "osc low power in default mode");
    repeat (DLY + 10) @(posedge core_clk);
    rd(32'(A_STAT), 32'h3, 32'h7, RESP_OK);
    follow(15, 4);
  endtask

  task test_gating;
    follow(0, 8);
    hw_clk_req[G_TMR] <= 1'b1;
    follow(0, 0);
    hw_clk_req <= '0;
    wr(32'(A_GATE), 32'h3F, RESP_OK);
  endtask

  task test_timers;
    wr(32'(A_SEL), 32'hE4E4, RESP_OK);
    rd(32'(A_SEL), 32'hE4E4, 32'hFFFFFFFF, RESP_OK);
    for (n = 0; n < 8; n++) follow(n, (n % 4 == 3) ? 2 : n % 4);
  endtask

  task test_uart_card_cam;
    for (n = 0; n < 4; n++) begin
      wr(32'(A_CONF), 32'(n), RESP_OK);
      follow(M_UART, (n == 0) ? 0 : (n == 1) ? 4 : 3);
    end
    wr(32'(A_CONF), 32'hC, RESP_OK);
    follow(M_CARD, 3);
    follow(M_CAM, 3);
  endtask

  task test_osc_pins;
    wr(32'(A_CONF), 32'h30, RESP_OK);
    follow(M_CARD, 2);
    follow(M_CAM, 2);
    follow(0, 7);
    chk({31'h0, rtc_pd}, 32'h1, "rtc powerdown");
    chk({31'h0, oe_b}, 32'h0, "osc pin driven");
    chk({31'h0, osc_o}, 32'h0, "osc pin level");
  endtask

  task test_gpio;
    follow(M_GPIO, 4);
    wr(32'(A_CAM), 32'h4, RESP_OK);
    follow(M_GPIO, 8);
  endtask

  task test_display_usb;
    follow(M_DISP, 5);
    wr(32'(A_SEL), 32'h000F0000, RESP_OK);
    edges(M_DISP, 256, 8);
    follow(M_USB, 3);
    edges(14, 64, 16);
  endtask

  // only the low five address bits decode, so the unmapped word sits inside them
  task test_bus_errors;
    wr(32'h1D, 32'h1, RESP_ERR);
    wr(32'(A_STAT), 32'h1, RESP_ERR);
    rd(32'h1D, 32'h0, 32'hFFFFFFFF, RESP_ERR);
  endtask

  task test_alt_mode;
    do_reset(1'b1);
    rd(32'(A_STAT), 32'h7, 32'hF, RESP_OK);
    chk({31'h0, lowpwr}, 32'h1, "osc low power");
    follow(15, 8);
    follow(M_GPIO, 8);
    wr(32'(A_BALL), 32'(BALL_SYSCLK), RESP_OK);
    wr(32'(A_COMPAT), 32'h0000EAEF, RESP_OK);
    rd(32'(A_COMPAT), 32'h0000EAEF, 32'hFFFFFFFF, RESP_OK);
    follow(15, 6);
    follow(M_GPIO, 6);
  endtask

  initial begin
    rst_b = 1'b0;
    rst_mode_strap = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 32'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    araddr = 32'h0;
    hw_clk_req = '0;
    cnt = 5'h0;
    watch = 0;
    src = 8;
    num_errors = 0;
    checks = 0;
    test_reset_wait;
    test_gating;
    test_timers;
    test_uart_card_cam;
    test_osc_pins;
    test_gpio;
    test_display_usb;
    test_bus_errors;
    test_alt_mode;
    conclude;
  end

  // whole run is a few thousand cycles; this bound only catches a hang
  initial begin
    #300000;
    num_errors++;
    conclude;
  end
endmodule
